// >>> verilog/rtc_drift_comp.sv
// Drift compensator: corrected divider chain, clock output, countdown timer and registers
//
// What this block does
// - Latch new correction value each 32 s period
// - Correct the reference at first divider stage
// - Insert pulses to speed, remove to slow
// - Spread pulses evenly, one pulse per step of about 0.95 ppm (1 in 2^20 ticks)
// - Raw 32.768 kHz output stays uncorrected
// - 1024, 32, 1 Hz outputs come after correction
// - Timer and seconds use the corrected chain
// - Single seconds vary; period average is exact
// - Scan bit selects 1 s or 16 s, enable bit runs thermometer
// - Output select reaches compensated 1024 or 1 Hz
// - Source and count writes need run and autoreload both clear
// - Autoreload repeats the countdown, else one shot
// - Source select 01 gives an 8 Hz tick
// - Count in two bytes; 8 Hz, 7 gives 1 Hz
// - Interrupt enable lets expiry reach the pin
// - Interrupt pin active low, falls at event
// - Writing zero to flag releases the pin
`timescale 1ns/10ps
`include "rtc_comp_map.svh"

module rtc_drift_comp
   import rtc_comp_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   nrst,
   input  wire logic   refClkIn,
   input  wire wbReq_s wbReq,
   output wbRsp_s      wbRsp,
   output logic        clockOutputPin,
   output logic        intN,
   output logic        secondTick,
   output logic        tempScanReq
);

   state_s      q;
   state_s      d;
   logic        refRise;
   logic        slotEnd;
   logic        periodEnd;
   logic [7:0]  mag;
   logic [8:0]  accSum;
   logic        corrNow;
   logic        insert;
   logic [1:0]  inc;
   logic [15:0] divSum;
   logic [14:0] divFall;
   logic        srcTick;
   logic        timerEvent;
   logic        access;
   logic        wr;
   logic        locked;

   // ==========================================================================
   // Next-state logic
   always_comb begin
      d          = q;
      d.secTick  = 1'b0;
      d.scanReq  = 1'b0;
      timerEvent = 1'b0;

      // Reference edge and 32 s period bookkeeping
      refRise   = refClkIn & ~q.refPrev;
      d.refPrev = refClkIn;
      slotEnd   = refRise && (q.periodCnt[`SLOT_W-1:0] == '1);
      periodEnd = refRise && (q.periodCnt == '1);
      if (refRise) begin
         d.periodCnt = q.periodCnt + 20'h0_0001;
      end

      // Even spread: mag pulses over 128 slots of 8192 ticks
      mag     = q.compApplied[7] ? 8'(-q.compApplied) : q.compApplied;
      accSum  = {1'b0, q.acc} + {1'b0, mag};
      corrNow = slotEnd && (accSum >= `SLOT_COUNT);
      insert  = ~q.compApplied[7];
      if (slotEnd) begin
         d.acc = corrNow ? 8'(accSum - `SLOT_COUNT) : accSum[7:0];
      end
      if (periodEnd) begin
         d.acc         = `RST_BYTE;
         d.compApplied = q.compPending;
      end

      // First divider stage: add two, add none, or add one per reference tick
      if (!refRise) begin
         inc = 2'h0;
      end else if (corrNow) begin
         inc = insert ? 2'h2 : 2'h0;
      end else begin
         inc = 2'h1;
      end
      divSum   = {1'b0, q.divCnt} + {14'h0000, inc};
      d.divCnt = divSum[`DIV_W-1:0];
      divFall  = q.divCnt & ~d.divCnt;
      d.secTick = divSum[`DIV_W];

      // Clock output select
      case (q.clkOutDivSel)
         CLK_RAW:  d.clock_output_pin = refClkIn;
         CLK_1024: d.clock_output_pin = d.divCnt[`TAP_1024HZ];
         CLK_32:   d.clock_output_pin = d.divCnt[`TAP_32HZ];
         default:  d.clock_output_pin = d.divCnt[`TAP_1HZ];
      endcase

      // Temperature scan requests every 1 s or every 16 s
      if (d.secTick && q.thermEn) begin
         if (!q.tempScanPeriodSel) begin
            d.scanReq = 1'b1;
         end else begin
            d.scanCnt = q.scanCnt + 4'h1;
            d.scanReq = (q.scanCnt == `SCAN_LONG_LAST);
         end
      end

      // Countdown source tick from the corrected chain
      case (q.srcSel)
         SRC_4096: srcTick = divFall[`TAP_4096HZ];
         SRC_8:    srcTick = divFall[`TAP_8HZ];
         SRC_1:    srcTick = divFall[`TAP_1HZ];
         default:  srcTick = divFall[`TAP_32HZ];
      endcase

      // Countdown: n+1 source ticks per event
      if (q.countdownRun && srcTick) begin
         if (q.timerCnt == `RST_WORD) begin
            timerEvent = 1'b1;
            if (q.countdownAutoreload) begin
               d.timerCnt = q.timerLoad;
            end else begin
               d.countdownRun = 1'b0;
            end
         end else begin
            d.timerCnt = q.timerCnt - 16'h0001;
         end
      end

      // Wishbone slave: one wait state, ack for one cycle
      access     = wbReq.cyc && wbReq.stb && !q.rsp.ack;
      wr         = access && wbReq.we && wbReq.sel[0];
      locked     = q.countdownRun || q.countdownAutoreload;
      d.rsp.ack  = access;
      d.rsp.dat  = 32'h0000_0000;
      if (wr) begin
         if (wbReq.adr == `ADR_CTRL1) begin
            d.countdownRun        = wbReq.dat[`BIT_RUN];
            d.countdownAutoreload = wbReq.dat[`BIT_AUTORELOAD];
            if (!locked) begin
               d.srcSel = srcSel_e'(wbReq.dat[`BIT_SRC_HI:`BIT_SRC_LO]);
            end
            if (!q.countdownRun && wbReq.dat[`BIT_RUN]) begin
               d.timerCnt = q.timerLoad;
            end
         end else if (wbReq.adr == `ADR_INT_CTRL) begin
            d.countdownIrqEn = wbReq.dat[`BIT_IRQ_EN];
         end else if (wbReq.adr == `ADR_INT_FLAG) begin
            if (!wbReq.dat[`BIT_EVENT_FLAG]) begin
               d.countdownEventFlag = 1'b0;
            end
         end else if (wbReq.adr == `ADR_TIMER_LO) begin
            if (!locked) begin
               d.timerLoad[7:0] = wbReq.dat[7:0];
            end
         end else if (wbReq.adr == `ADR_TIMER_HI) begin
            if (!locked) begin
               d.timerLoad[15:8] = wbReq.dat[7:0];
            end
         end else if (wbReq.adr == `ADR_THERM_CLK) begin
            d.tempScanPeriodSel = wbReq.dat[`BIT_SCAN_SEL];
            d.thermEn           = wbReq.dat[`BIT_THERM_EN];
            d.clkOutDivSel      = clkSel_e'(wbReq.dat[`BIT_CLKSEL_HI:`BIT_CLKSEL_LO]);
         end else if (wbReq.adr == `ADR_COMP_VALUE) begin
            d.compPending = wbReq.dat[7:0];
         end
      end else if (access && !wbReq.we) begin
         if (wbReq.adr == `ADR_CTRL1) begin
            d.rsp.dat[`BIT_RUN]                  = q.countdownRun;
            d.rsp.dat[`BIT_AUTORELOAD]           = q.countdownAutoreload;
            d.rsp.dat[`BIT_SRC_HI:`BIT_SRC_LO]   = q.srcSel;
         end else if (wbReq.adr == `ADR_INT_CTRL) begin
            d.rsp.dat[`BIT_IRQ_EN] = q.countdownIrqEn;
         end else if (wbReq.adr == `ADR_INT_FLAG) begin
            d.rsp.dat[`BIT_EVENT_FLAG] = q.countdownEventFlag;
         end else if (wbReq.adr == `ADR_TIMER_LO) begin
            d.rsp.dat[7:0] = q.timerLoad[7:0];
         end else if (wbReq.adr == `ADR_TIMER_HI) begin
            d.rsp.dat[7:0] = q.timerLoad[15:8];
         end else if (wbReq.adr == `ADR_THERM_CLK) begin
            d.rsp.dat[`BIT_SCAN_SEL]                = q.tempScanPeriodSel;
            d.rsp.dat[`BIT_THERM_EN]                = q.thermEn;
            d.rsp.dat[`BIT_CLKSEL_HI:`BIT_CLKSEL_LO] = q.clkOutDivSel;
         end else if (wbReq.adr == `ADR_COMP_VALUE) begin
            d.rsp.dat[7:0] = q.compPending;
         end else if (wbReq.adr == `ADR_STATUS) begin
            d.rsp.dat = {8'h00, q.compApplied, q.timerCnt};
         end
      end

      // Event sets the flag after any clear, so set wins
      if (timerEvent) begin
         d.countdownEventFlag = 1'b1;
      end
      d.intN = ~(d.countdownEventFlag & d.countdownIrqEn);
   end

   // ==========================================================================
   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q                     <= '0;
         q.srcSel              <= srcSel_e'(`RST_SRCSEL);
         q.clkOutDivSel        <= clkSel_e'(`RST_CLKSEL);
         q.intN                <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign wbRsp          = q.rsp;
   assign clockOutputPin = q.clock_output_pin;
   assign intN           = q.intN;
   assign secondTick     = q.secTick;
   assign tempScanReq    = q.scanReq;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_latch_at_period;
      $changed(q.compApplied) |-> $past(periodEnd);
   endproperty
   a_latch_at_period: assert property (p_latch_at_period)
      else $error("Correction value changed inside a period");

   property p_insert_adds_two;
      corrNow && insert |=> q.divCnt == 15'($past(q.divCnt) + 15'h0002);
   endproperty
   a_insert_adds_two: assert property (p_insert_adds_two)
      else $error("Inserted pulse did not advance divider by two");

   property p_remove_holds;
      corrNow && !insert |=> $stable(q.divCnt);
   endproperty
   a_remove_holds: assert property (p_remove_holds)
      else $error("Removed pulse still advanced divider");

   property p_acc_bounded;
      {1'b0, q.acc} < `SLOT_COUNT;
   endproperty
   a_acc_bounded: assert property (p_acc_bounded)
      else $error("Spread accumulator out of range");

   property p_raw_out;
      q.clkOutDivSel == CLK_RAW && $stable(q.clkOutDivSel) |=> clockOutputPin == $past(refClkIn);
   endproperty
   a_raw_out: assert property (p_raw_out)
      else $error("Raw clock output not following reference");

   property p_locked_load;
      locked && wr |=> $stable(q.timerLoad) && $stable(q.srcSel);
   endproperty
   a_locked_load: assert property (p_locked_load)
      else $error("Timer setting changed while timer active");

   property p_reload;
      timerEvent && q.countdownAutoreload && !(wr && wbReq.adr == `ADR_CTRL1)
         |=> q.timerCnt == $past(q.timerLoad) && q.countdownRun;
   endproperty
   a_reload: assert property (p_reload)
      else $error("Countdown did not reload");

   property p_one_shot;
      timerEvent && !q.countdownAutoreload && !wr |=> !q.countdownRun;
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("One-shot countdown kept running");

   property p_event_flag;
      timerEvent |=> q.countdownEventFlag ##0 (intN == !q.countdownIrqEn);
   endproperty
   a_event_flag: assert property (p_event_flag)
      else $error("Event did not set flag or pin");

   property p_pin_level;
      intN == !(q.countdownEventFlag && q.countdownIrqEn);
   endproperty
   a_pin_level: assert property (p_pin_level)
      else $error("Interrupt pin disagrees with flag and enable");

   property p_flag_clear;
      wr && wbReq.adr == `ADR_INT_FLAG && !wbReq.dat[`BIT_EVENT_FLAG] && !timerEvent
         |=> !q.countdownEventFlag ##0 intN;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Flag clear did not release pin");

   property p_scan_off;
      !$past(q.thermEn) |-> !tempScanReq;
   endproperty
   a_scan_off: assert property (p_scan_off)
      else $error("Scan request with thermometer off");

   property p_ack_pulse;
      wbRsp.ack |=> !wbRsp.ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("Ack held for more than one cycle");

   property p_period_applies;
      periodEnd |=> q.compApplied == $past(q.compPending);
   endproperty
   a_period_applies: assert property (p_period_applies)
      else $error("Pending correction not applied at period end");

   property p_tick_only;
      !refRise |=> $stable(q.divCnt);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("Divider moved without a reference tick");

   property p_plain_tick;
      refRise && !corrNow |=> q.divCnt == 15'($past(q.divCnt) + 15'h0001);
   endproperty
   a_plain_tick: assert property (p_plain_tick)
      else $error("Uncorrected tick did not advance divider by one");

   property p_scan_on_second;
      d.secTick && q.thermEn && !q.tempScanPeriodSel |=> tempScanReq;
   endproperty
   a_scan_on_second: assert property (p_scan_on_second)
      else $error("No scan request at second with 1 s interval");

   property p_ack_answer;
      wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("Bus request not answered after one cycle");

   c_insert: cover property (corrNow && insert);
   c_remove: cover property (corrNow && !insert);
   c_reload: cover property (timerEvent && q.countdownAutoreload);
   c_int_fall: cover property ($fell(intN));
   c_second: cover property (secondTick && tempScanReq);

endmodule

// >>> verilog/rtc_comp_map.svh
// Register offsets, field positions, reset values and divider taps of the drift compensator
`ifndef RTC_COMP_MAP_SVH
`define RTC_COMP_MAP_SVH

// ==========================================================================
// Register byte addresses
`define ADR_CTRL1       8'h00
`define ADR_INT_CTRL    8'h04
`define ADR_INT_FLAG    8'h08
`define ADR_TIMER_LO    8'h0C
`define ADR_TIMER_HI    8'h10
`define ADR_THERM_CLK   8'h14
`define ADR_COMP_VALUE  8'h18
`define ADR_STATUS      8'h1C

// ==========================================================================
// Field positions
`define BIT_RUN         1
`define BIT_AUTORELOAD  2
`define BIT_SRC_LO      5
`define BIT_SRC_HI      6
`define BIT_IRQ_EN      1
`define BIT_EVENT_FLAG  1
`define BIT_SCAN_SEL    0
`define BIT_THERM_EN    1
`define BIT_CLKSEL_LO   2
`define BIT_CLKSEL_HI   3

// ==========================================================================
// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RST_CLKSEL      2'h0
`define RST_SRCSEL      2'h0

// ==========================================================================
// Timing: reference ticks per second and per 32 s compensation period
`define REF_HZ          32768
`define COMP_PERIOD_S   32
`define PERIOD_TICKS    (`COMP_PERIOD_S * `REF_HZ)
`define PERIOD_W        20
`define SLOT_W          13
`define SLOT_COUNT      9'h080
`define SCAN_LONG_LAST  4'hF

// ==========================================================================
// Divider taps (bit k falls once every 2^(k+1) corrected ticks)
`define DIV_W           15
`define TAP_1024HZ      4
`define TAP_32HZ        9
`define TAP_1HZ         14
`define TAP_4096HZ      2
`define TAP_8HZ         11

`endif

// >>> verilog/rtc_comp_pkg.sv
// Types shared by the drift compensator: bus carriers, selects and the state record
package rtc_comp_pkg;

   // ==========================================================================
   // Classic Wishbone request and response
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wbReq_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wbRsp_s;

   // ==========================================================================
   // Clock output and countdown source selects
   typedef enum logic [1:0] {CLK_RAW, CLK_1024, CLK_32, CLK_1} clkSel_e;
   typedef enum logic [1:0] {SRC_4096, SRC_8, SRC_1, SRC_32} srcSel_e;

   // ==========================================================================
   // Whole state of the compensator
   typedef struct packed {
      wbRsp_s      rsp;
      logic        refPrev;
      logic [19:0] periodCnt;
      logic [7:0]  acc;
      logic [7:0]  compPending;
      logic [7:0]  compApplied;
      logic [14:0] divCnt;
      logic        countdownRun;
      logic        countdownAutoreload;
      srcSel_e     srcSel;
      logic        countdownIrqEn;
      logic        countdownEventFlag;
      logic [15:0] timerLoad;
      logic [15:0] timerCnt;
      logic        tempScanPeriodSel;
      logic        thermEn;
      clkSel_e     clkOutDivSel;
      logic [3:0]  scanCnt;
      logic        clock_output_pin;
      logic        intN;
      logic        secTick;
      logic        scanReq;
   } state_s;

endpackage

// >>> dv/ref_osc_model.sv
// Reference oscillator model standing in for the crystal, sped up for simulation
`timescale 1ns/10ps

module ref_osc_model #(
   parameter int HALF = 1
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   output logic      refClk
);
   int unsigned cnt;

   // ==========================================================================
   // Free running square wave; a crystal never stops, so it runs through idle
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         refClk <= 1'b0;
         cnt    <= 0;
      end else if (cnt == HALF - 1) begin
         refClk <= ~refClk;
         cnt    <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// >>> dv/test_rtc_drift_compensation.sv
// Self-checking bench for the drift compensator: registers, clock output and countdown
`timescale 1ns/10ps
`include "rtc_comp_map.svh"

module test_rtc_drift_compensation;
   import rtc_comp_pkg::*;

   logic        core_clk = 1'b0;
   logic        nrst;
   logic        refClkIn;
   wbReq_s      wbReq;
   wbRsp_s      wbRsp;
   logic        clockOutputPin;
   logic        intN;
   logic        secondTick;
   logic        tempScanReq;
   logic        refPrev  = 1'b0;
   int unsigned ticks    = 0;
   int          num_errors = 0;
   int          checks   = 0;

   // ==========================================================================
   // Clock, reference source and design
   always #2.5 core_clk = ~core_clk;

   ref_osc_model ref_osc_model_inst (
      .core_clk (core_clk),
      .nrst     (nrst),
      .refClk   (refClkIn)
   );

   rtc_drift_comp rtc_drift_comp_inst (
      .core_clk       (core_clk),
      .nrst           (nrst),
      .refClkIn       (refClkIn),
      .wbReq          (wbReq),
      .wbRsp          (wbRsp),
      .clockOutputPin (clockOutputPin),
      .intN           (intN),
      .secondTick     (secondTick),
      .tempScanReq    (tempScanReq)
   );

   // Reference tick count, the yardstick for every period measured below
   always @(posedge core_clk) begin
      refPrev <= refClkIn;
      if (refClkIn && !refPrev) ticks <= ticks + 1;
   end

   // ==========================================================================
   // Shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   // Classic single cycle; holds the request until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      // Ack registers one edge after the request is taken, so it is seen at the second
      do begin
         @(posedge core_clk);
         n++;
      end while (wbRsp.ack !== 1'b1);
      q = wbRsp.dat;
      chk("bus ack cycles", 2, n);
      wbReq <= '0;
      @(posedge core_clk);
   endtask

   task automatic wbw(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic wbr(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0000_0000, q);
   endtask

   // Waits for a rise of the clock pin, or a fall of the interrupt pin; returns tick stamp
   task automatic waitEv(input bit useClk, output int unsigned t);
      logic s;
      logic p;
      int   n;
      p = useClk ? clockOutputPin : ~intN;
      n = 0;
      forever begin
         @(posedge core_clk);
         n++;
         s = useClk ? clockOutputPin : ~intN;
         if ((s === 1'b1 && p === 1'b0) || n >= 30000) break;
         p = s;
      end
      t = ticks;
      if (n >= 30000) chk("edge wait", 1, 0);
   endtask

   // Programs the countdown with the timer stopped, starts it, waits for the first event
   task automatic timerStart(input logic [31:0] ctrl, input logic [7:0] cnt,
                             output int unsigned t0);
      wbw(`ADR_CTRL1, 32'h0000_0000);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      wbw(`ADR_CTRL1, ctrl);
      wbw(`ADR_TIMER_LO, {24'h00_0000, cnt});
      wbw(`ADR_TIMER_HI, 32'h0000_0000);
      wbw(`ADR_INT_CTRL, 32'h0000_0002);
      wbw(`ADR_CTRL1, ctrl | 32'h0000_0006);
      waitEv(1'b0, t0);
   endtask

   // ==========================================================================
   // Scenarios
   task automatic test_reset;
      logic [31:0] q;
      chk("int pin after reset", 1, intN);
      wbr(`ADR_CTRL1, q);
      chk("control reset", 0, q);
      wbw(8'h40, 32'h0000_00FF);
      wbr(8'h40, q);
      chk("unmapped read", 0, q);
      wbw(`ADR_COMP_VALUE, 32'h0000_0005);
      wbr(`ADR_STATUS, q);
      chk("correction held to period end", 0, q[23:16]);
      $display("test_reset done");
   endtask

   task automatic test_raw;
      int unsigned t0;
      int          rises;
      logic        p;
      t0 = ticks;
      rises = 0;
      p = clockOutputPin;
      repeat (100) begin
         @(posedge core_clk);
         if (clockOutputPin === 1'b1 && p === 1'b0) rises++;
         p = clockOutputPin;
      end
      chk("raw clock rises", ticks - t0, rises);
      $display("test_raw done");
   endtask

   task automatic test_clock_output_pin;
      logic [31:0] q;
      int unsigned t0;
      int unsigned t1;
      wbw(`ADR_THERM_CLK, 32'h0000_0006);
      wbr(`ADR_THERM_CLK, q);
      chk("thermometer and clock select", 32'h0000_0006, q);
      waitEv(1'b1, t0);
      waitEv(1'b1, t0);
      waitEv(1'b1, t1);
      chk("1024 Hz period", 32, t1 - t0);
      wbw(`ADR_THERM_CLK, 32'h0000_000A);
      waitEv(1'b1, t0);
      waitEv(1'b1, t0);
      waitEv(1'b1, t1);
      chk("32 Hz period", 1024, t1 - t0);
      wbw(`ADR_THERM_CLK, 32'h0000_0000);
      $display("test_clock_output_pin done");
   endtask

   task automatic test_timer;
      logic [31:0] q;
      int unsigned t0;
      int unsigned t1;
      timerStart(32'h0000_0000, 8'h03, t0);
      chk("pin low at event", 0, intN);
      wbr(`ADR_INT_FLAG, q);
      chk("event flag", 1, q[1]);
      wbw(`ADR_TIMER_LO, 32'h0000_0009);
      wbr(`ADR_TIMER_LO, q);
      chk("count locked while running", 3, q[7:0]);
      wbw(`ADR_INT_FLAG, 32'h0000_0002);
      chk("pin after writing one", 0, intN);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      chk("pin after flag clear", 1, intN);
      waitEv(1'b0, t1);
      chk("4096 Hz event period", 32, t1 - t0);
      wbw(`ADR_CTRL1, 32'h0000_0000);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      $display("test_timer done");
   endtask

   task automatic test_8hz;
      int unsigned t0;
      int unsigned t1;
      timerStart(32'h0000_0020, 8'h00, t0);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      waitEv(1'b0, t1);
      chk("8 Hz event period", 4096, t1 - t0);
      wbw(`ADR_CTRL1, 32'h0000_0000);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      $display("test_8hz done");
   endtask

   task automatic test_oneshot;
      logic [31:0] q;
      logic        lowSeen;
      int          n;
      wbw(`ADR_INT_CTRL, 32'h0000_0000);
      wbw(`ADR_TIMER_LO, 32'h0000_0002);
      wbw(`ADR_CTRL1, 32'h0000_0062); // 32 Hz source, run, no reload
      lowSeen = 1'b0;
      q = 32'h0000_0000;
      n = 0;
      while (q[1] !== 1'b1 && n < 3000) begin
         wbr(`ADR_INT_FLAG, q);
         lowSeen = lowSeen | (intN !== 1'b1);
         n++;
      end
      chk("one shot flag", 1, q[1]);
      chk("masked pin stays high", 0, lowSeen);
      wbr(`ADR_CTRL1, q);
      chk("run after one shot", 0, q[1]);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      $display("test_oneshot done");
   endtask

   // First corrected second: tick, scan request, 1 Hz output and 1 Hz timer all line up
   task automatic test_second;
      logic p;
      wbw(`ADR_THERM_CLK, 32'h0000_000E);
      wbw(`ADR_CTRL1, 32'h0000_0040);
      wbw(`ADR_TIMER_LO, 32'h0000_0000);
      wbw(`ADR_INT_CTRL, 32'h0000_0002);
      wbw(`ADR_CTRL1, 32'h0000_0042);
      do begin
         p = clockOutputPin;
         @(posedge core_clk);
      end while (secondTick !== 1'b1);
      chk("ticks per second", 0, ticks % `REF_HZ);
      chk("scan request at second", 1, tempScanReq);
      chk("1 Hz output before second", 1, p);
      chk("1 Hz output at second", 0, clockOutputPin);
      chk("1 Hz timer event at second", 0, intN);
      wbw(`ADR_CTRL1, 32'h0000_0000);
      wbw(`ADR_INT_FLAG, 32'h0000_0000);
      wbw(`ADR_THERM_CLK, 32'h0000_0000);
      $display("test_second done");
   endtask

   // ==========================================================================
   // Verdict and run control
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog sized about a fifth above the longest expected run, which reaches the first second near cycle 65536
   initial begin
      repeat (80000) @(posedge core_clk);
      num_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      end_sim;
   end

   // Main sequence: reset for 10 cycles, then each scenario in turn
   initial begin
      nrst  = 1'b0;
      wbReq = '0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      test_reset;
      test_raw;
      test_clock_output_pin;
      test_timer;
      test_8hz;
      test_oneshot;
      test_second;
      end_sim;
   end
endmodule
